// File: src/frp_regs.sv
/*
 * Function register and read-parameter register of a serial flash, with their
 * SPI instructions, protection checks and read timing decode.
 * Assumes SPI mode 0 on the pins; core suspend, resume and request inputs are on clk.
 */
// Function
// - 8-bit function register: reserved, top/bottom, suspend flags, four row locks.
// - Top/bottom select and row locks are one-time programmable, back to zero only on reset.
// - Protection area counts from the top when select is zero, bottom when one.
// - Program suspend flag sets on suspend during program, clears on resume.
// - Erase suspend flag sets on suspend during erase, clears on resume.
// - Programming information row n is refused while its lock bit is one.
// - Volatile read-parameter register: drive, dummy, wrap, burst; resets to E0h.
// - Opcode C0h plus one data byte loads the whole read-parameter register.
// - Burst length codes 00..11 give 8, 16, 32, 64 bytes.
// - Wrap disabled reads run the whole array; enabled wraps at burst boundary.
// - Normal read uses no dummy; single-line fast, dual, quad output use eight.
// - Quad I/O and quad-mode fast read use 6, 4, 8, 10 by setting.
// - Dual I/O reads and DTR reads use their own per-setting tables; single-line DTR fast read uses four.
// - Dummy counts include the mode-bit cycles, nothing added on top.
// - Unique-ID, discoverable-parameter and row reads use the fast read count.
// - Drive codes map to 12.5, 25, 37.5, 75, 100, 50 percent; two reserved.
// - Program or erase inside the protected block area is refused.
`timescale 1ns/1ps
module frp_regs #(
    parameter int BLOCK_COUNT = 128,
    parameter int BLOCK_BITS = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // SPI pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    // Core operation status
    input wire logic program_active,
    input wire logic erase_active,
    input wire logic suspend_pulse,
    input wire logic resume_pulse,
    // Protection checks
    input wire logic [3:0] block_protect,
    input wire logic [BLOCK_BITS-1:0] target_block,
    input wire logic prog_erase_req,
    output logic prog_erase_allowed,
    input wire logic info_row_req,
    input wire logic [1:0] info_row_sel,
    output logic info_row_allowed,
    // Read timing query
    input wire logic [7:0] read_opcode,
    input wire logic quad_command_mode,
    output logic [3:0] dummy_cycles,
    // Register views
    output frp_pkg::frp_func_s func_reg,
    output frp_pkg::frp_rdpar_s rdpar_reg,
    output logic wrap_enabled,
    output logic [6:0] burst_bytes,
    output logic [9:0] drive_tenths,
    output logic drive_reserved
);
    import frp_pkg::*;

    if (BLOCK_COUNT != (1 << BLOCK_BITS) || BLOCK_BITS < 6) begin : g_chk
        $error("BLOCK_COUNT must be a power of two of at least 64 matching BLOCK_BITS");
    end

    typedef enum {ST_IDLE, ST_DATA_FUNC, ST_DATA_RDPAR, ST_READOUT, ST_IGNORE} frp_state_e;

    // Number of protected blocks for a protect code
    function automatic logic [BLOCK_BITS:0] protect_count(input logic [3:0] bp);
        if (bp[3]) return BLOCK_COUNT[BLOCK_BITS:0];
        if (bp == 4'h0) return '0;
        return (BLOCK_BITS+1)'(1) << (bp[2:0] - 3'h1);
    endfunction : protect_count

    logic rise, fall, frame_end, byte_valid;
    logic [7:0] rx_byte;
    logic [3:0] lut_dummy;

    frp_spi_rx u_rx (
        .clk(clk),
        .arst_n(arst_n),
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .rise(rise),
        .fall(fall),
        .frame_end(frame_end),
        .byte_valid(byte_valid),
        .rx_byte(rx_byte)
    );

    frp_dummy_lut u_lut (
        .opcode(read_opcode),
        .quad_command_mode(quad_command_mode),
        .dummy_sel(rdpar_reg.dummy_sel),
        .dummy_cycles(lut_dummy)
    );

    // ==========================================================
    // Instruction decoding and register state
    frp_state_e state_q, state_d;
    frp_func_s func_q, func_d;
    frp_rdpar_s rdpar_q, rdpar_d;
    logic [7:0] data_q, data_d;
    logic [7:0] opcode_q, opcode_d;
    logic data_seen_q, data_seen_d;
    logic extra_q, extra_d;
    logic wel_q, wel_d;
    logic [7:0] shift_q, shift_d;
    logic so_q, so_d, oe_n_q, oe_n_d;
    logic commit_func, commit_rdpar;

    // A write lands only when exactly one data byte came before select rose
    assign commit_func = frame_end && state_q == ST_DATA_FUNC && data_seen_q && !extra_q;
    assign commit_rdpar = frame_end && state_q == ST_DATA_RDPAR && data_seen_q && !extra_q;

    // Next state of the command engine and both registers
    always_comb begin
        state_d = state_q;
        func_d = func_q;
        rdpar_d = rdpar_q;
        data_d = data_q;
        opcode_d = opcode_q;
        data_seen_d = data_seen_q;
        extra_d = extra_q;
        wel_d = wel_q;
        shift_d = shift_q;
        so_d = so_q;
        oe_n_d = oe_n_q;
        case (state_q)
            ST_IDLE: begin
                if (byte_valid) begin
                    opcode_d = rx_byte;
                    data_seen_d = 1'b0;
                    extra_d = 1'b0;
                    case (rx_byte)
                        OP_WRITE_FUNCTION: state_d = wel_q ? ST_DATA_FUNC : ST_IGNORE;
                        OP_SET_READ_PARAMS: state_d = ST_DATA_RDPAR;
                        OP_READ_FUNCTION: begin
                            state_d = ST_READOUT;
                            shift_d = func_q;
                        end
                        default: state_d = ST_IGNORE;
                    endcase
                end
            end
            ST_DATA_FUNC, ST_DATA_RDPAR: begin
                if (byte_valid) begin
                    data_d = rx_byte;
                    extra_d = data_seen_q;
                    data_seen_d = 1'b1;
                end
            end
            ST_READOUT: begin
                if (fall) begin
                    so_d = shift_q[7];
                    oe_n_d = 1'b0;
                    shift_d = {shift_q[6:0], shift_q[7]};
                end
            end
            ST_IGNORE: state_d = ST_IGNORE;
            default: state_d = ST_IDLE;
        endcase
        if (frame_end) begin
            state_d = ST_IDLE;
            oe_n_d = 1'b1;
            if (state_q == ST_IGNORE && opcode_q == OP_WRITE_ENABLE) wel_d = 1'b1;
            if (state_q == ST_IGNORE && opcode_q == OP_WRITE_DISABLE) wel_d = 1'b0;
        end
        // OTP bits can only go up; reserved and suspend bits ignore writes
        if (commit_func) begin
            func_d = func_q | (data_q & FUNC_OTP_MASK);
            wel_d = 1'b0;
        end
        if (commit_rdpar) rdpar_d = data_q;
        // Suspend flags: a suspend in the same cycle as a resume wins
        if (resume_pulse) begin
            func_d.program_suspended_flag = 1'b0;
            func_d.erase_suspended_flag = 1'b0;
        end
        if (suspend_pulse && program_active) func_d.program_suspended_flag = 1'b1;
        if (suspend_pulse && erase_active) func_d.erase_suspended_flag = 1'b1;
        func_d.reserved = 1'b0;
    end

    // Command engine registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            func_q <= FUNC_RESET;
            rdpar_q <= RDPAR_RESET;
            data_q <= 8'h00;
            opcode_q <= 8'h00;
            data_seen_q <= 1'b0;
            extra_q <= 1'b0;
            wel_q <= 1'b0;
            shift_q <= 8'h00;
            so_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            func_q <= func_d;
            rdpar_q <= rdpar_d;
            data_q <= data_d;
            opcode_q <= opcode_d;
            data_seen_q <= data_seen_d;
            extra_q <= extra_d;
            wel_q <= wel_d;
            shift_q <= shift_d;
            so_q <= so_d;
            oe_n_q <= oe_n_d;
        end
    end

    // ==========================================================
    // Registered decode outputs
    logic pe_ok_q, pe_ok_d, ir_ok_q, ir_ok_d;
    logic [3:0] dummy_q, dummy_d;
    logic wrap_q, wrap_d, drv_res_q, drv_res_d;
    logic [6:0] burst_q, burst_d;
    logic [9:0] drive_q, drive_d;
    logic [BLOCK_BITS:0] prot_n;

    // Protection, lock, burst, drive and dummy decode
    always_comb begin
        prot_n = protect_count(block_protect);
        if (func_q.top_bottom_select) begin
            pe_ok_d = {1'b0, target_block} >= prot_n;
        end else begin
            pe_ok_d = {1'b0, target_block} < (BLOCK_COUNT[BLOCK_BITS:0] - prot_n);
        end
        pe_ok_d = prog_erase_req && pe_ok_d;
        ir_ok_d = info_row_req && !func_q.info_row_lock[info_row_sel];
        wrap_d = rdpar_q.wrap_enable;
        burst_d = BURST_BASE << rdpar_q.burst_len;
        drive_d = DRIVE_TENTHS[rdpar_q.drive_strength];
        drv_res_d = rdpar_q.drive_strength[1:0] == 2'h0;
        dummy_d = lut_dummy;
    end

    // Decode registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pe_ok_q <= 1'b0;
            ir_ok_q <= 1'b0;
            dummy_q <= 4'h0;
            wrap_q <= 1'b0;
            burst_q <= BURST_BASE;
            drive_q <= DRIVE_TENTHS[7];
            drv_res_q <= 1'b0;
        end else begin
            pe_ok_q <= pe_ok_d;
            ir_ok_q <= ir_ok_d;
            dummy_q <= dummy_d;
            wrap_q <= wrap_d;
            burst_q <= burst_d;
            drive_q <= drive_d;
            drv_res_q <= drv_res_d;
        end
    end

    assign so = so_q;
    assign so_oe_n = oe_n_q;
    assign func_reg = func_q;
    assign rdpar_reg = rdpar_q;
    assign prog_erase_allowed = pe_ok_q;
    assign info_row_allowed = ir_ok_q;
    assign dummy_cycles = dummy_q;
    assign wrap_enabled = wrap_q;
    assign burst_bytes = burst_q;
    assign drive_tenths = drive_q;
    assign drive_reserved = drv_res_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_rdpar_commit;
        frame_end && state_q == ST_DATA_RDPAR && data_seen_q && !extra_q;
    endsequence
    sequence s_func_write;
        frame_end && state_q == ST_DATA_FUNC && data_seen_q && !extra_q;
    endsequence

    property p_otp_sticky;
        $rose(func_q.top_bottom_select) |=> func_q.top_bottom_select [*8];
    endproperty
    a_otp_sticky: assert property (p_otp_sticky) else $error("otp select dropped");
    property p_lock_sticky;
        func_q.info_row_lock != 4'h0 |=> (func_q.info_row_lock & $past(func_q.info_row_lock))
            == $past(func_q.info_row_lock);
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("row lock dropped");
    property p_func_or;
        s_func_write |=> {func_q[7:4], func_q[1]}
            == ($past({func_q[7:4], func_q[1]}) | $past({data_q[7:4], data_q[1]}));
    endproperty
    a_func_or: assert property (p_func_or) else $error("function write wrong");
    property p_rdpar_load;
        s_rdpar_commit |=> rdpar_q == $past(data_q);
    endproperty
    a_rdpar_load: assert property (p_rdpar_load) else $error("read params not loaded");
    property p_program_suspended_flag_set;
        suspend_pulse && program_active |=> func_q.program_suspended_flag;
    endproperty
    a_program_suspended_flag_set: assert property (p_program_suspended_flag_set) else $error("program suspend not set");
    property p_erase_suspended_flag_set;
        suspend_pulse && erase_active |=> func_q.erase_suspended_flag;
    endproperty
    a_erase_suspended_flag_set: assert property (p_erase_suspended_flag_set) else $error("erase suspend not set");
    property p_resume_clear;
        resume_pulse && !suspend_pulse |=> !func_q.program_suspended_flag
            && !func_q.erase_suspended_flag;
    endproperty
    a_resume_clear: assert property (p_resume_clear) else $error("resume kept flag");
    property p_reserved_zero;
        func_q.reserved == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
    property p_lock_refuse;
        info_row_req && func_q.info_row_lock[info_row_sel] |=> !info_row_allowed;
    endproperty
    a_lock_refuse: assert property (p_lock_refuse) else $error("locked row allowed");
    property p_all_protected;
        block_protect[3] |=> !prog_erase_allowed;
    endproperty
    a_all_protected: assert property (p_all_protected) else $error("protected op allowed");
    property p_normal_read;
        read_opcode == OP_NORMAL_READ |=> dummy_cycles == 4'h0;
    endproperty
    a_normal_read: assert property (p_normal_read) else $error("normal read dummy");
    property p_burst;
        rdpar_q.burst_len == 2'h3 |=> burst_bytes == 7'h40;
    endproperty
    a_burst: assert property (p_burst) else $error("burst decode wrong");

endmodule : frp_regs

// File: src/frp_pkg.sv
/*
 * Shared constants and carriers for the flash function and read-parameter registers.
 * Assumes a single system clock of 50 MHz; SPI pins are sampled on that clock.
 */
package frp_pkg;

    // ==========================================================
    // Instruction opcodes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_WRITE_FUNCTION = 8'h42;
    localparam logic [7:0] OP_READ_FUNCTION = 8'h48;
    localparam logic [7:0] OP_SET_READ_PARAMS = 8'hC0;
    localparam logic [7:0] OP_NORMAL_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
    localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
    localparam logic [7:0] OP_DTR_FAST_READ = 8'h0D;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] OP_DUAL_IO_DTR_READ = 8'hBD;
    localparam logic [7:0] OP_QUAD_IO_DTR_READ = 8'hED;
    localparam logic [7:0] OP_READ_UNIQUE_ID = 8'h4B;
    localparam logic [7:0] OP_READ_DISC_PARAMS = 8'h5A;
    localparam logic [7:0] OP_INFO_ROW_READ = 8'h68;

    // ==========================================================
    // Register layouts and reset values
    typedef struct packed {
        logic [3:0] info_row_lock;
        logic erase_suspended_flag;
        logic program_suspended_flag;
        logic top_bottom_select;
        logic reserved;
    } frp_func_s;

    typedef struct packed {
        logic [2:0] drive_strength;
        logic [1:0] dummy_sel;
        logic wrap_enable;
        logic [1:0] burst_len;
    } frp_rdpar_s;

    localparam logic [7:0] FUNC_RESET = 8'h00;
    localparam logic [7:0] RDPAR_RESET = 8'hE0;
    localparam logic [7:0] FUNC_OTP_MASK = 8'hF2;
    localparam int FUNC_TBS_POS = 1;
    localparam int FUNC_LOCK_POS = 4;

    // ==========================================================
    // Dummy cycle counts; the four tables are indexed by the dummy-cycle setting
    localparam logic [3:0] DUMMY_NONE = 4'h0;
    localparam logic [3:0] DUMMY_SPI_FAST = 4'h8;
    localparam logic [3:0] DUMMY_SPI_DTR = 4'h4;
    localparam logic [3:0] DUMMY_QUAD [0:3] = '{4'h6, 4'h4, 4'h8, 4'hA};
    localparam logic [3:0] DUMMY_QUAD_DTR [0:3] = '{4'h3, 4'h2, 4'h4, 4'h5};
    localparam logic [3:0] DUMMY_DUAL_IO [0:3] = '{4'h4, 4'h4, 4'h8, 4'h8};
    localparam logic [3:0] DUMMY_DUAL_DTR [0:3] = '{4'h2, 4'h2, 4'h4, 4'h4};

    // ==========================================================
    // Drive strength in tenths of a percent, indexed by code
    localparam logic [9:0] DRIVE_TENTHS [0:7] = '{10'h000, 10'h07D, 10'h0FA, 10'h177,
                                                 10'h000, 10'h2EE, 10'h3E8, 10'h1F4};
    localparam logic [6:0] BURST_BASE = 7'h08;

endpackage : frp_pkg

// File: src/frp_spi_rx.sv
/*
 * SPI mode 0 receiver: synchronises the pins, finds clock and select edges, shifts bytes.
 * Assumes the serial clock is several system clocks long in each phase.
 */
`timescale 1ns/1ps
module frp_spi_rx (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    // Events
    output logic rise,
    output logic fall,
    output logic frame_end,
    output logic byte_valid,
    output logic [7:0] rx_byte
);
    import frp_pkg::*;

    logic [2:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic [1:0] prev_q, prev_d;
    logic [2:0] cnt_q, cnt_d;
    logic [6:0] shreg_q, shreg_d;
    logic [7:0] byte_q, byte_d;
    logic bv_q, bv_d;

    // ==========================================================
    // Edge detection on the second synchroniser stage
    assign rise = !sync2_q[0] && sync2_q[1] && !prev_q[0];
    assign fall = !sync2_q[0] && !sync2_q[1] && prev_q[0];
    assign frame_end = sync2_q[0] && !prev_q[1];
    assign byte_valid = bv_q;
    assign rx_byte = byte_q;

    // Next values of sync, counter and shifter
    always_comb begin
        sync1_d = {si, sck, cs_n};
        sync2_d = sync1_q;
        prev_d = {sync2_q[0], sync2_q[1]};
        cnt_d = cnt_q;
        shreg_d = shreg_q;
        byte_d = byte_q;
        bv_d = 1'b0;
        if (sync2_q[0]) begin
            cnt_d = 3'h0;
        end else if (rise) begin
            cnt_d = cnt_q + 3'h1;
            shreg_d = {shreg_q[5:0], sync2_q[2]};
            if (cnt_q == 3'h7) begin
                byte_d = {shreg_q, sync2_q[2]};
                bv_d = 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 3'h1;
            sync2_q <= 3'h1;
            prev_q <= 2'h2;
            cnt_q <= 3'h0;
            shreg_q <= 7'h00;
            byte_q <= 8'h00;
            bv_q <= 1'b0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q <= prev_d;
            cnt_q <= cnt_d;
            shreg_q <= shreg_d;
            byte_q <= byte_d;
            bv_q <= bv_d;
        end
    end

endmodule : frp_spi_rx

// File: src/frp_dummy_lut.sv
/*
 * Dummy cycle lookup for every read opcode, mode-bit cycles included in the count.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
module frp_dummy_lut (
    // Query
    input wire logic [7:0] opcode,
    input wire logic quad_command_mode,
    input wire logic [1:0] dummy_sel,
    // Result
    output logic [3:0] dummy_cycles
);
    import frp_pkg::*;

    // ==========================================================
    // Table select; counts already cover the mode-bit byte
    always_comb begin
        case (opcode)
            OP_NORMAL_READ: dummy_cycles = DUMMY_NONE;
            OP_FAST_READ, OP_READ_UNIQUE_ID, OP_READ_DISC_PARAMS, OP_INFO_ROW_READ: begin
                dummy_cycles = quad_command_mode ? DUMMY_QUAD[dummy_sel]
                                                 : DUMMY_SPI_FAST;
            end
            OP_DUAL_OUT_READ, OP_QUAD_OUT_READ: dummy_cycles = DUMMY_SPI_FAST;
            OP_QUAD_IO_READ: dummy_cycles = DUMMY_QUAD[dummy_sel];
            OP_DTR_FAST_READ: begin
                dummy_cycles = quad_command_mode ? DUMMY_QUAD_DTR[dummy_sel]
                                                 : DUMMY_SPI_DTR;
            end
            OP_QUAD_IO_DTR_READ: dummy_cycles = DUMMY_QUAD_DTR[dummy_sel];
            OP_DUAL_IO_READ: dummy_cycles = DUMMY_DUAL_IO[dummy_sel];
            OP_DUAL_IO_DTR_READ: dummy_cycles = DUMMY_DUAL_DTR[dummy_sel];
            default: dummy_cycles = DUMMY_NONE;
        endcase
    end

endmodule : frp_dummy_lut

// File: tb/frp_host_model.sv
/*
 * Host model that drives the serial pins of the register block.
 * Assumes clk is the block clock; pins change 1 ns after its rising edge.
 */
`timescale 1ns/1ps
module frp_host_model (
    // System clock
    input wire logic clk,
    // Serial pins
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    // ==========================================================
    // Idle pins: serial clock stands still low outside frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // ==========================================================
    // One frame of n bits, MSB first, so captured before each fall
    task automatic frame(input logic [15:0] d, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk) #1;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = d[15 - i];
            repeat (4) @(posedge clk) #1;
            sck = 1'b1;
            repeat (3) @(posedge clk) #1;
            rd = {rd[6:0], so};
            @(posedge clk) #1;
            sck = 1'b0;
        end
        repeat (4) @(posedge clk) #1;
        cs_n = 1'b1;
        si = ~si; // Released line shows the inverse value
        repeat (8) @(posedge clk) #1;
    endtask : frame
endmodule : frp_host_model

// File: tb/frp_regs_tb.sv
/*
 * Self-checking bench for the function and read-parameter registers.
 * Assumes frp_pkg, the design and frp_host_model are compiled first.
 */
`timescale 1ns/1ps
module frp_regs_tb;
    import frp_pkg::*;
    // ==========================================================
    // Signals and tables
    logic clk, arst_n, sck, cs_n, si, so, so_oe_n;
    logic program_active, erase_active, suspend_pulse, resume_pulse;
    logic [3:0] block_protect, dummy_cycles;
    logic [6:0] target_block, burst_bytes;
    logic prog_erase_req, prog_erase_allowed, info_row_req, info_row_allowed;
    logic [1:0] info_row_sel;
    logic [7:0] read_opcode, rd;
    logic quad_command_mode, wrap_enabled, drive_reserved;
    logic [9:0] drive_tenths;
    frp_func_s func_reg;
    frp_rdpar_s rdpar_reg;
    int errors = 0;
    int n_compared = 0;
    localparam logic [9:0] TENTHS [0:7] = '{10'h000, 10'h07D, 10'h0FA, 10'h177,
                                           10'h000, 10'h2EE, 10'h3E8, 10'h1F4};
    localparam logic [3:0] QT [0:3] = '{4'h6, 4'h4, 4'h8, 4'hA};
    localparam logic [3:0] QDT [0:3] = '{4'h3, 4'h2, 4'h4, 4'h5};
    localparam logic [7:0] OPS [0:11] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hEB, 8'h0D,
                                         8'hBB, 8'hBD, 8'hED, 8'h4B, 8'h5A, 8'h68};

    frp_regs dut (.clk, .arst_n, .sck, .cs_n, .si, .so, .so_oe_n, .program_active,
        .erase_active, .suspend_pulse, .resume_pulse, .block_protect, .target_block,
        .prog_erase_req, .prog_erase_allowed, .info_row_req, .info_row_sel,
        .info_row_allowed, .read_opcode, .quad_command_mode, .dummy_cycles, .func_reg,
        .rdpar_reg, .wrap_enabled, .burst_bytes, .drive_tenths, .drive_reserved);
    frp_host_model host (.clk, .sck, .cs_n, .si, .so);

    // Clock of 20 ns
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========================================================
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [3:0] exp_dummy(logic [7:0] op, logic q, logic [1:0] s);
        case (op)
            8'h0B, 8'h4B, 8'h5A, 8'h68: return q ? QT[s] : 4'h8;
            8'h3B, 8'h6B: return 4'h8;
            8'hEB: return QT[s];
            8'hED: return QDT[s];
            8'h0D: return q ? QDT[s] : 4'h4;
            8'hBB: return s[1] ? 4'h8 : 4'h4;
            8'hBD: return s[1] ? 4'h4 : 4'h2;
            default: return 4'h0;
        endcase
    endfunction : exp_dummy

    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk(func_reg, 8'h00);
        chk(rdpar_reg, 8'hE0);
        chk({burst_bytes, wrap_enabled, drive_tenths}, {7'h08, 1'b0, 10'h1F4});
        $display("done reset values");
    endtask : t_reset

    task automatic t_rdpar();
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            d = {i[2:0], i[1:0], i[0], i[1:0]};
            host.frame({OP_SET_READ_PARAMS, d}, 16, rd);
            step(2);
            chk(rdpar_reg, d);
            chk(burst_bytes, 7'h08 << d[1:0]);
            chk(wrap_enabled, d[2]);
            chk({drive_tenths, drive_reserved}, {TENTHS[d[7:5]], d[6:5] == 2'b00});
        end
        $display("done read parameters");
    endtask : t_rdpar

    task automatic t_dummy();
        logic q;
        for (int s = 0; s < 4; s++) begin
            host.frame({OP_SET_READ_PARAMS, 3'b111, s[1:0], 3'b000}, 16, rd);
            for (int k = 0; k < 24; k++) begin
                read_opcode = OPS[k % 12];
                q = 1'(k / 12);
                quad_command_mode = q;
                step(2);
                chk(dummy_cycles, exp_dummy(read_opcode, q, 2'(s)));
            end
        end
        $display("done dummy cycles");
    endtask : t_dummy

    task automatic prot(input logic [6:0] blk, input logic [1:0] row, input logic [1:0] exp);
        target_block = blk;
        info_row_sel = row;
        step(2);
        chk({prog_erase_allowed, info_row_allowed}, exp);
    endtask : prot

    task automatic t_otp();
        block_protect = 4'h1;
        prog_erase_req = 1'b1;
        info_row_req = 1'b1;
        prot(7'h7F, 2'h0, 2'b01);
        prot(7'h00, 2'h0, 2'b11);
        host.frame({OP_WRITE_FUNCTION, 8'h1F}, 16, rd);
        chk(func_reg, 8'h00);
        host.frame({OP_WRITE_ENABLE, 8'h00}, 8, rd);
        host.frame({OP_WRITE_FUNCTION, 8'h1F}, 16, rd);
        chk(func_reg, 8'h12);
        prot(7'h00, 2'h0, 2'b00);
        prot(7'h7F, 2'h1, 2'b11);
        block_protect = 4'h7;
        prot(7'h3F, 2'h1, 2'b01);
        prot(7'h40, 2'h1, 2'b11);
        block_protect = 4'h8;
        prot(7'h40, 2'h1, 2'b01);
        host.frame({OP_WRITE_ENABLE, 8'h00}, 8, rd);
        host.frame({OP_WRITE_FUNCTION, 8'h00}, 16, rd);
        chk(func_reg, 8'h12);
        host.frame({OP_WRITE_ENABLE, 8'h00}, 8, rd);
        host.frame({OP_WRITE_DISABLE, 8'h00}, 8, rd);
        host.frame({OP_WRITE_FUNCTION, 8'hFF}, 16, rd);
        chk(func_reg, 8'h12);
        host.frame({OP_READ_FUNCTION, 8'h00}, 16, rd);
        chk({rd, so_oe_n}, {8'h12, 1'b1});
        $display("done one-time bits");
    endtask : t_otp

    task automatic t_susp();
        for (int e = 0; e < 2; e++) begin
            program_active = (e == 0);
            erase_active = (e == 1);
            suspend_pulse = 1'b1;
            step(1);
            suspend_pulse = 1'b0;
            step(1);
            chk(func_reg[3:2], (e == 1) ? 2'b10 : 2'b01);
            resume_pulse = 1'b1;
            step(1);
            resume_pulse = 1'b0;
            step(1);
            chk(func_reg[3:2], 2'b00);
        end
        suspend_pulse = 1'b1;
        resume_pulse = 1'b1;
        step(1);
        {suspend_pulse, resume_pulse} = 2'b00;
        step(1);
        chk(func_reg[3:2], 2'b10);
        $display("done suspend flags");
    endtask : t_susp

    // Watchdog against a hung run
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        give_verdict();
    end

    // Main sequence
    initial begin
        {arst_n, program_active, erase_active, suspend_pulse, resume_pulse} = 5'h00;
        {block_protect, target_block, prog_erase_req, info_row_req} = 13'h0000;
        {info_row_sel, read_opcode, quad_command_mode} = 11'h000;
        step(5);
        arst_n = 1'b1;
        step(3);
        t_reset();
        t_rdpar();
        t_dummy();
        arst_n = 1'b0;
        step(2);
        arst_n = 1'b1;
        step(3);
        t_reset();
        t_otp();
        t_susp();
        give_verdict();
    end
endmodule : frp_regs_tb
